// file: src/fcs_defines.vh
// Constants of the flash command controller: offsets, fields, commands, timing
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// Clock rate and time to cycles, least times round up
`define FCS_CLK_MHZ        100
`define FCS_CYC_UP(ns)     ((((ns) * `FCS_CLK_MHZ) + 999) / 1000)

// Bus cycle times in ns
`define FCS_T_AS_NS        10
`define FCS_T_WP_NS        35
`define FCS_T_WPH_NS       30
`define FCS_T_ACC_NS       70
`define FCS_T_BUSY_NS      90
`define FCS_T_RP_NS        500
`define FCS_T_RH_NS        50
`define FCS_T_AS           `FCS_CYC_UP(`FCS_T_AS_NS)
`define FCS_T_WP           `FCS_CYC_UP(`FCS_T_WP_NS)
`define FCS_T_WPH          `FCS_CYC_UP(`FCS_T_WPH_NS)
`define FCS_T_ACC          `FCS_CYC_UP(`FCS_T_ACC_NS)
`define FCS_T_BUSY         `FCS_CYC_UP(`FCS_T_BUSY_NS)
`define FCS_T_RP           `FCS_CYC_UP(`FCS_T_RP_NS)
`define FCS_T_RH           `FCS_CYC_UP(`FCS_T_RH_NS)
// Extra strobe cycles covering the two-stage data synchroniser
`define FCS_SYNC_LAT       2

// Register byte offsets
`define FCS_REG_CTRL       8'h00
`define FCS_REG_ADDR       8'h04
`define FCS_REG_WDATA      8'h08
`define FCS_REG_STATUS     8'h0C
`define FCS_REG_RDATA      8'h10
`define FCS_REG_CFG        8'h14

// Field positions
`define FCS_CTRL_OP_LSB    0
`define FCS_CTRL_GO_BIT    8
`define FCS_CFG_ELEV_BIT   0
`define FCS_ST_BUSY_BIT    0
`define FCS_ST_DONE_BIT    1
`define FCS_ST_XTIME_BIT   2
`define FCS_ST_READY_BIT   3
`define FCS_ST_REFUSE_BIT  4
`define FCS_XTIME_DQ_BIT   5

// Operation codes
`define FCS_OP_READ        3'h0
`define FCS_OP_PROG        3'h1
`define FCS_OP_ASEL        3'h2
`define FCS_OP_RESET       3'h3
`define FCS_OP_HWRST       3'h4

// Command address/data values
`define FCS_UNL1_ADDR      20'h0_0555
`define FCS_UNL1_DATA      8'hAA
`define FCS_UNL2_ADDR      20'h0_02AA
`define FCS_UNL2_DATA      8'h55
`define FCS_PROG_DATA      8'hA0
`define FCS_ASEL_DATA      8'h90
`define FCS_RESET_DATA     8'hF0

// AXI responses
`define FCS_RESP_OKAY      2'b00
`define FCS_RESP_SLVERR    2'b10

`endif

// file: src/fcs_cycle.v
// One flash bus cycle, write or read, on the parallel pins
`timescale 1ns/1ns
`include "fcs_defines.vh"

module fcs_cycle (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Cycle request
  input  wire        start,
  input  wire        wr,
  input  wire [19:0] addr,
  input  wire [7:0]  wdata,
  output reg         done_q,
  output reg  [7:0]  rdata_q,
  // Flash pins
  output reg  [19:0] fl_addr_q,
  output reg  [7:0]  data_lines_o_q,
  output reg  [7:0]  data_lines_oe_q,
  input  wire [7:0]  data_lines_i,
  output reg         fl_ce_n_q,
  output reg         fl_oe_n_q,
  output reg         fl_we_n_q
);

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_SET  = 4'b0010;
  localparam [3:0] S_STRB = 4'b0100;
  localparam [3:0] S_HOLD = 4'b1000;

  localparam integer C_AS  = `FCS_T_AS;
  localparam integer C_WP  = `FCS_T_WP;
  localparam integer C_WPH = `FCS_T_WPH;
  localparam integer C_RD  = `FCS_T_ACC + `FCS_SYNC_LAT;

  reg [3:0] st_q;
  reg [7:0] cnt_q;
  reg       wr_q;
  reg [7:0] dsync1_q;
  reg [7:0] dsync2_q;

  // Two-stage synchroniser on read data
  always @(posedge aclk) begin
    dsync1_q <= data_lines_i;
    dsync2_q <= dsync1_q;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q            <= S_IDLE;
      cnt_q           <= 8'h00;
      wr_q            <= 1'b0;
      done_q          <= 1'b0;
      rdata_q         <= 8'h00;
      fl_addr_q       <= 20'h0_0000;
      data_lines_o_q  <= 8'h00;
      data_lines_oe_q <= 8'h00;
      fl_ce_n_q       <= 1'b1;
      fl_oe_n_q       <= 1'b1;
      fl_we_n_q       <= 1'b1;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start) begin
            // Address settles with all strobes high
            wr_q            <= wr;
            fl_addr_q       <= addr;
            data_lines_o_q  <= wdata;
            data_lines_oe_q <= wr ? 8'hFF : 8'h00;
            cnt_q           <= C_AS[7:0];
            st_q            <= S_SET;
          end
        end
        S_SET: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            // Write only with CE and WE low and OE high; pulse spans many ns
            fl_ce_n_q <= 1'b0;
            fl_we_n_q <= ~wr_q;
            fl_oe_n_q <= wr_q;
            cnt_q     <= wr_q ? C_WP[7:0] : C_RD[7:0];
            st_q      <= S_STRB;
          end
        end
        S_STRB: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            // Address and data stay put across both strobe edges
            if (!wr_q) begin
              rdata_q <= dsync2_q;
            end
            fl_ce_n_q <= 1'b1;
            fl_we_n_q <= 1'b1;
            fl_oe_n_q <= 1'b1;
            cnt_q     <= C_WPH[7:0];
            st_q      <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            data_lines_oe_q <= 8'h00;
            done_q          <= 1'b1;
            st_q            <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: src/fcs_ctrl.v
// Host-side controller driving a parallel flash command interface, AXI4-Lite registers
// Operation
// - Host protects every unprotected sector before the first unprotect write; the controller has no protect command, only the CFG elevated-level bit.
// - Protect/unprotect at elevated reset level uses ordinary bus cycle timing.
// - Write starts only with CE and WE low and OE high.
// - On exceeded-time flag the host writes reset; device returns to read-array.
// - Byte program is two unlocks, set-up, then address and data.
// - Autoselect persists until the host writes a reset command.
`timescale 1ns/1ns
`include "fcs_defines.vh"

module fcs_ctrl (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Flash pins
  output wire [19:0] fl_addr,
  output wire [7:0]  data_lines_o,
  output wire [7:0]  data_lines_oe,
  input  wire [7:0]  data_lines_i,
  output wire        fl_ce_n,
  output wire        fl_oe_n,
  output wire        fl_we_n,
  output reg         fl_reset_n_q,
  output reg         elev_id_en_q,
  input  wire        ready_busy_output
);

  localparam [6:0] S_IDLE  = 7'b000_0001;
  localparam [6:0] S_ISSUE = 7'b000_0010;
  localparam [6:0] S_WAIT  = 7'b000_0100;
  localparam [6:0] S_SETTL = 7'b000_1000;
  localparam [6:0] S_POLL  = 7'b001_0000;
  localparam [6:0] S_PWAIT = 7'b010_0000;
  localparam [6:0] S_HRST  = 7'b100_0000;

  localparam integer C_BUSY = `FCS_T_BUSY;
  localparam integer C_RP   = `FCS_T_RP;
  localparam integer C_RH   = `FCS_T_RH;

  // Software registers
  reg  [2:0]  op_q;
  reg  [19:0] addr_q;
  reg  [7:0]  wdata_q;
  reg  [7:0]  rdata_q;
  reg         done_flag_q;
  reg         xtime_flag_q;
  reg         refuse_flag_q;
  // Sequencer
  reg  [6:0]  st_q;
  reg  [2:0]  run_op_q;
  reg  [1:0]  step_q;
  reg  [7:0]  tmr_q;
  reg         rec_q;
  reg         cyc_start_q;
  reg         cyc_wr_q;
  reg  [19:0] cyc_addr_q;
  reg  [7:0]  cyc_data_q;
  // Ready/busy synchroniser
  reg         rb_s1_q;
  reg         rb_s2_q;
  // AXI write side
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;

  wire        cyc_done;
  wire [7:0]  cyc_rdata;
  wire        busy;
  wire [31:0] status;
  wire [31:0] ctrl_new;
  wire        go;
  wire [31:0] addr_new;

  // One cycle of a command sequence: {write, address, data}
  function [28:0] seq_word;
    input [2:0]  op;
    input [1:0]  step;
    input [19:0] a;
    input [7:0]  d;
    begin
      if (op == `FCS_OP_READ) begin
        seq_word = {1'b0, a, 8'h00};
      end else if (op == `FCS_OP_RESET) begin
        seq_word = {1'b1, a, `FCS_RESET_DATA};
      end else if (step == 2'd0) begin
        seq_word = {1'b1, `FCS_UNL1_ADDR, `FCS_UNL1_DATA};
      end else if (step == 2'd1) begin
        seq_word = {1'b1, `FCS_UNL2_ADDR, `FCS_UNL2_DATA};
      end else if (step == 2'd2) begin
        seq_word = {1'b1, `FCS_UNL1_ADDR,
                    (op == `FCS_OP_PROG) ? `FCS_PROG_DATA : `FCS_ASEL_DATA};
      end else begin
        seq_word = {1'b1, a, d};
      end
    end
  endfunction

  // Last step index of each sequence
  function [1:0] last_step;
    input [2:0] op;
    begin
      case (op)
        `FCS_OP_PROG: last_step = 2'd3;
        `FCS_OP_ASEL: last_step = 2'd2;
        default:      last_step = 2'd0;
      endcase
    end
  endfunction

  // Byte-lane merge of a write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  assign busy     = (st_q != S_IDLE);
  assign addr_new = merge({12'h000, addr_q}, w_data_q, w_strb_q);
  assign status   = {27'h000_0000, refuse_flag_q, rb_s2_q, xtime_flag_q, done_flag_q, busy};
  assign ctrl_new = merge({23'h00_0000, 6'h00, op_q}, w_data_q, w_strb_q);
  assign go       = aw_got_q && w_got_q && !s_axi_bvalid
                    && (aw_addr_q == `FCS_REG_CTRL) && ctrl_new[`FCS_CTRL_GO_BIT];

  fcs_cycle u_cycle (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .start           (cyc_start_q),
    .wr              (cyc_wr_q),
    .addr            (cyc_addr_q),
    .wdata           (cyc_data_q),
    .done_q          (cyc_done),
    .rdata_q         (cyc_rdata),
    .fl_addr_q       (fl_addr),
    .data_lines_o_q  (data_lines_o),
    .data_lines_oe_q (data_lines_oe),
    .data_lines_i    (data_lines_i),
    .fl_ce_n_q       (fl_ce_n),
    .fl_oe_n_q       (fl_oe_n),
    .fl_we_n_q       (fl_we_n)
  );

  always @(posedge aclk) begin
    rb_s1_q <= ready_busy_output;
    rb_s2_q <= rb_s1_q;
  end

  // AXI4-Lite slave and register file
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FCS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `FCS_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      op_q          <= `FCS_OP_READ;
      addr_q        <= 20'h0_0000;
      wdata_q       <= 8'h00;
      elev_id_en_q  <= 1'b0;
      refuse_flag_q <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `FCS_RESP_OKAY;
        case (aw_addr_q)
          `FCS_REG_CTRL: begin
            op_q <= ctrl_new[`FCS_CTRL_OP_LSB +: 3];
            if (ctrl_new[`FCS_CTRL_GO_BIT]) begin
              refuse_flag_q <= busy;
            end
          end
          `FCS_REG_ADDR:   addr_q  <= addr_new[19:0];
          `FCS_REG_WDATA:  wdata_q <= w_strb_q[0] ? w_data_q[7:0] : wdata_q;
          `FCS_REG_STATUS: s_axi_bresp <= `FCS_RESP_OKAY;
          `FCS_REG_RDATA:  s_axi_bresp <= `FCS_RESP_OKAY;
          // Elevated level; software protects every sector before unprotecting
          `FCS_REG_CFG: begin
            if (w_strb_q[0]) begin
              elev_id_en_q <= w_data_q[`FCS_CFG_ELEV_BIT];
            end
          end
          default:         s_axi_bresp <= `FCS_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `FCS_RESP_OKAY;
        case (s_axi_araddr)
          `FCS_REG_CTRL:   s_axi_rdata <= {29'h0000_0000, op_q};
          `FCS_REG_ADDR:   s_axi_rdata <= {12'h000, addr_q};
          `FCS_REG_WDATA:  s_axi_rdata <= {24'h00_0000, wdata_q};
          `FCS_REG_STATUS: s_axi_rdata <= status;
          `FCS_REG_RDATA:  s_axi_rdata <= {24'h00_0000, rdata_q};
          `FCS_REG_CFG:    s_axi_rdata <= {31'h0000_0000, elev_id_en_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FCS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Command sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= S_IDLE;
      run_op_q     <= `FCS_OP_READ;
      step_q       <= 2'd0;
      tmr_q        <= 8'h00;
      rec_q        <= 1'b0;
      cyc_start_q  <= 1'b0;
      cyc_wr_q     <= 1'b0;
      cyc_addr_q   <= 20'h0_0000;
      cyc_data_q   <= 8'h00;
      rdata_q      <= 8'h00;
      done_flag_q  <= 1'b0;
      xtime_flag_q <= 1'b0;
      fl_reset_n_q <= 1'b1;
    end else begin
      cyc_start_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (go) begin
            run_op_q     <= ctrl_new[`FCS_CTRL_OP_LSB +: 3];
            step_q       <= 2'd0;
            done_flag_q  <= 1'b0;
            xtime_flag_q <= 1'b0;
            if (ctrl_new[`FCS_CTRL_OP_LSB +: 3] == `FCS_OP_HWRST) begin
              // Hard reset aborts programming and returns to read-array
              fl_reset_n_q <= 1'b0;
              rec_q        <= 1'b0;
              tmr_q        <= C_RP[7:0];
              st_q         <= S_HRST;
            end else begin
              st_q <= S_ISSUE;
            end
          end
        end
        S_ISSUE: begin
          // Whole, in-order sequences are sent for defined op codes; codes 5 to 7 send only the first unlock write
          {cyc_wr_q, cyc_addr_q, cyc_data_q} <=
            seq_word(run_op_q, step_q, addr_q, wdata_q);
          cyc_start_q <= 1'b1;
          st_q        <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (step_q != last_step(run_op_q)) begin
              step_q <= step_q + 2'd1;
              st_q   <= S_ISSUE;
            end else if (run_op_q == `FCS_OP_PROG) begin
              tmr_q <= C_BUSY[7:0];
              st_q  <= S_SETTL;
            end else begin
              if (run_op_q == `FCS_OP_READ) begin
                rdata_q <= cyc_rdata;
              end
              done_flag_q <= 1'b1;
              st_q        <= S_IDLE;
            end
          end
        end
        S_SETTL: begin
          // Give ready/busy time to fall after the last program write
          if (tmr_q > 8'h01) begin
            tmr_q <= tmr_q - 8'h01;
          end else begin
            st_q <= S_POLL;
          end
        end
        S_POLL: begin
          // While the device reports busy only status reads go out, plus the reset write once the exceeded-time bit is set
          if (rb_s2_q) begin
            done_flag_q <= 1'b1;
            st_q        <= S_IDLE;
          end else begin
            {cyc_wr_q, cyc_addr_q, cyc_data_q} <= {1'b0, addr_q, 8'h00};
            cyc_start_q <= 1'b1;
            st_q        <= S_PWAIT;
          end
        end
        S_PWAIT: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            if (rb_s2_q) begin
              done_flag_q <= 1'b1;
              st_q        <= S_IDLE;
            end else if (cyc_rdata[`FCS_XTIME_DQ_BIT]) begin
              // Exceeded time: write reset to get back to read-array
              xtime_flag_q <= 1'b1;
              run_op_q     <= `FCS_OP_RESET;
              step_q       <= 2'd0;
              st_q         <= S_ISSUE;
            end else begin
              st_q <= S_POLL;
            end
          end
        end
        S_HRST: begin
          if (tmr_q > 8'h01) begin
            tmr_q <= tmr_q - 8'h01;
          end else if (!rec_q) begin
            fl_reset_n_q <= 1'b1;
            rec_q        <= 1'b1;
            tmr_q        <= C_RH[7:0];
          end else begin
            done_flag_q <= 1'b1;
            st_q        <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: test/fcs_ctrl_props.sv
// Checker of flash pin sequencing on the controller's ports
`timescale 1ns/1ns
module fcs_ctrl_props (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Flash pins
  input wire [19:0] fl_addr,
  input wire [7:0]  data_lines_o,
  input wire [7:0]  data_lines_oe,
  input wire        fl_ce_n,
  input wire        fl_oe_n,
  input wire        fl_we_n,
  input wire        fl_reset_n_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_we_strobe_ok: assert property (!fl_we_n |-> fl_oe_n && !fl_ce_n)
    else $error("write strobe without select or with read enable");
  chk_read_released: assert property (!fl_oe_n |-> data_lines_oe == 8'h00 && fl_we_n)
    else $error("data driven during read");
  chk_write_driven: assert property (!fl_we_n |-> data_lines_oe == 8'hFF)
    else $error("data not driven during write strobe");
  chk_we_width: assert property ($fell(fl_we_n) |=> !fl_we_n [*3])
    else $error("write strobe too short");
  chk_addr_stable: assert property (!fl_ce_n |-> $stable(fl_addr))
    else $error("address moved during strobe");
  chk_data_hold: assert property ($rose(fl_we_n) |-> $stable(data_lines_o) && data_lines_oe == 8'hFF)
    else $error("data not held at strobe rise");
  chk_strobe_gap: assert property ($rose(fl_ce_n) |=> fl_ce_n [*3])
    else $error("select high time too short");
  chk_rst_quiet: assert property (!fl_reset_n_q |-> fl_ce_n && fl_we_n && fl_oe_n)
    else $error("bus cycle during hard reset");
  chk_rst_width: assert property ($fell(fl_reset_n_q) |=> !fl_reset_n_q [*8])
    else $error("hard reset pulse too short");
  cover property ($fell(fl_we_n));
  cover property ($fell(fl_oe_n));
  cover property ($fell(fl_reset_n_q));
endmodule

// file: test/fcs_flash_model.sv
// Behavioural model of the parallel flash device
`timescale 1ns/1ns
module fcs_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'hC3  // arbitrary value
) (
  // Flash pins
  input  wire [19:0] fl_addr,
  input  wire [7:0]  data_lines_o,
  output wire [7:0]  data_lines_i,
  input  wire        fl_ce_n,
  input  wire        fl_oe_n,
  input  wire        fl_we_n,
  input  wire        fl_reset_n,
  input  wire        elev,
  output wire        ready_busy_output
);
  logic [7:0]  mem [logic [19:0]];
  logic [19:0] a_q;
  logic [2:0]  st = 0;
  logic        busy = 0;
  logic        xt = 0;
  logic [15:0] prot = 16'h0000;
  logic [7:0]  q;
  wire         wr_n = fl_ce_n | fl_we_n;
  wire [7:0]   d = data_lines_o;
  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  always @(negedge wr_n) a_q = fl_addr;
  always @(negedge fl_reset_n) begin
    st = 0;
    busy = 0;
    xt = 0;
  end
  always @(posedge wr_n) if (fl_oe_n && fl_reset_n) begin
    if (busy) begin
      if (xt && d == 8'hF0) begin
        busy = 0;
        xt = 0;
      end
    end else if (st == 3) begin
      xt = (rd(a_q) & d) != d;
      if (!prot[a_q[19:16]] || elev) mem[a_q] = rd(a_q) & d;
      busy = 1;
      st = 0;
      fork begin #400; if (!xt) busy = 0; end join_none
    end else if (d == 8'hF0) st = 0;
    else if (st == 0) st = (a_q[10:0] == 11'h555 && d == 8'hAA) ? 3'd1 : 3'd0;
    else if (st == 1) st = (a_q[10:0] == 11'h2AA && d == 8'h55) ? 3'd2 : 3'd0;
    else if (st == 2 && a_q[10:0] == 11'h555) st = d == 8'hA0 ? 3'd3 : d == 8'h90 ? 3'd4 : 3'd0;
    else if (st != 4) st = 0;
  end
  always @*
    if (busy) q = {2'b00, xt, 5'h00};
    else if (st == 4) q = fl_addr[7:0] == 0 ? MAKER_ID : fl_addr[7:0] == 1 ? PART_ID :
                          {7'h00, prot[fl_addr[19:16]]};
    else q = rd(fl_addr);
  // Released lines show the inverse so stale values never match
  assign data_lines_i = (!fl_ce_n && !fl_oe_n && fl_reset_n) ? q : ~q;
  assign ready_busy_output = !busy;
endmodule

// file: test/fcs_ctrl_tb_top.sv
// Self-checking bench of the flash command controller
`timescale 1ns/1ns
`include "fcs_defines.vh"
module fcs_ctrl_tb_top;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [19:0] fl_addr;
  wire  [7:0]  data_lines_o, data_lines_oe, data_lines_i;
  wire         fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n_q, elev_id_en_q, ready_busy_output;
  int          miscompares = 0, comparisons = 0;
  localparam logic [7:0] MK = 8'h5A, PT = 8'hC3; // arbitrary id values
  always #5 aclk = ~aclk;
  fcs_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fl_addr, .data_lines_o, .data_lines_oe, .data_lines_i,
    .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n_q, .elev_id_en_q, .ready_busy_output);
  fcs_flash_model #(.MAKER_ID(MK), .PART_ID(PT)) i_flash (.fl_addr, .data_lines_o,
    .data_lines_i, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n(fl_reset_n_q),
    .elev(elev_id_en_q), .ready_busy_output);
  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 300) begin
      miscompares++;
      $display("CHECK FAILED wait expected answer seen none");
      finish_test;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 300);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    bound(n);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 300);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    bound(n);
  endtask
  // Runs one operation and polls status until done
  task automatic op(input logic [2:0] o, input logic [19:0] a, input logic [7:0] d,
                    output logic [31:0] s);
    logic [1:0] r;
    int n;
    axw(8'h04, {12'h000, a}, r);
    axw(8'h08, {24'h00_0000, d}, r);
    axw(8'h00, {23'h0, 1'b1, 5'h00, o}, r);
    s = 0;
    for (n = 0; n < 300 && s[1] !== 1'b1; n++) axr(8'h0C, s, r);
    bound(n);
  endtask
  task automatic rdchk(input logic [19:0] a, input logic [7:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    op(`FCS_OP_READ, a, 8'h00, v);
    axr(8'h10, v, r);
    cmp("read byte", {24'h00_0000, exp}, v);
  endtask
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    logic [19:0] a, a0;
    logic [7:0]  d, d0;
    void'($urandom(32'hbf9f7c3a));
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (4) @(posedge aclk);
    axr(8'h0C, v, r);
    cmp("status after reset", 32'h0000_0008, v);
    axr(8'h18, v, r);
    cmp("unmapped read data", 32'h0000_0000, v);
    cmp("unmapped read resp", 32'h0000_0002, {30'h0, r});
    axw(8'h18, 32'hFFFF_FFFF, r);
    cmp("unmapped write resp", 32'h0000_0002, {30'h0, r});
    for (int i = 0; i < 4; i++) begin
      a = i == 0 ? 20'hF_FFFF : {i[3:0], 16'h0000} | 20'($urandom & 32'h0000_FFFF);
      d = i == 0 ? 8'h00 : 8'($urandom & 32'h0000_007F);
      if (i == 1) a0 = a;
      if (i == 1) d0 = d;
      op(`FCS_OP_PROG, a, d, v);
      cmp("program time flag", 32'h0, {31'h0, v[2]});
      rdchk(a, d);
    end
    axw(8'h00, 32'h0000_0100, r);
    axw(8'h00, 32'h0000_0100, r);
    axr(8'h0C, v, r);
    cmp("go while busy", 32'h0000_0019, v);
    repeat (40) @(posedge aclk);
    op(`FCS_OP_PROG, a0, d0 | 8'h80, v);
    cmp("raise bit time flag", 32'h1, {31'h0, v[2]});
    rdchk(a0, d0);
    for (int k = 0; k < 2; k++) begin
      axw(8'h14, {31'h0, k == 0}, r);
      axr(8'h14, v, r);
      cmp("elevated level reg", {31'h0, k == 0}, v);
      cmp("elevated level pin", {31'h0, k == 0}, {31'h0, elev_id_en_q});
      op(`FCS_OP_ASEL, 20'h0_0000, 8'h00, v);
      rdchk(20'h0_0000, MK);
      rdchk(20'h0_0001, PT);
      rdchk({a0[19:16], 16'h0002}, 8'h00);
      op(k == 0 ? `FCS_OP_RESET : `FCS_OP_HWRST, a0, 8'h00, v);
      rdchk(a0, d0);
    end
    finish_test;
  end
endmodule
bind fcs_ctrl fcs_ctrl_props i_props (.aclk, .aresetn, .fl_addr, .data_lines_o, .data_lines_oe,
  .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n_q);
